//--- hw/ppio_pkg.sv
// ppio_pkg: constants and carrier types for the parallel port block
// assumes a 16-bit register port with a word index address
package ppio_pkg;
  localparam int PPIO_W = 16;
  // ports 0..10 are bidirectional, 11 and 12 are input only
  localparam int PPIO_NBI = 11;
  localparam int PPIO_NALL = 13;
  // ports with output driver control registers
  localparam int PPIO_NDRV = 10;
  localparam int PPIO_XA = 10;
  localparam int PPIO_XB = 12;
  // port order: 8-bit p0l p0h p1l p1h, 16-bit p2, 15-bit p3,
  // 8-bit p4 p6 p7 p8, 16-bit ext a, 16-bit input p5, 16-bit input ext b
  localparam logic [PPIO_NALL-1:0][PPIO_W-1:0] PPIO_PORT_MASK = {
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
    16'hBFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};
  // ports whose drivers may be switched to open drain
  localparam logic [PPIO_NBI-1:0] PPIO_OD_PORTS = 11'h7F0;
  // register word index bases
  localparam logic [7:0] PPIO_DATA_BASE = 8'h00;
  localparam logic [7:0] PPIO_DIR_BASE = 8'h10;
  localparam logic [7:0] PPIO_SET_BASE = 8'h20;
  localparam logic [7:0] PPIO_CLR_BASE = 8'h30;
  localparam logic [7:0] PPIO_OD_BASE = 8'h40;
  localparam logic [7:0] PPIO_DRV_BASE = 8'h50;
  localparam logic [7:0] PPIO_STRB_DRV = 8'h5A;
  localparam logic [7:0] PPIO_THR_SEL = 8'h5B;
  // threshold select fields
  localparam int PPIO_THR_P2L = 0;
  localparam int PPIO_THR_P2H = 1;
  localparam int PPIO_THR_P3L = 2;
  localparam int PPIO_THR_P3H = 3;
  localparam int PPIO_THR_P4L = 4;
  localparam int PPIO_THR_P7L = 6;
  localparam int PPIO_THR_P8L = 7;
  localparam logic [7:0] PPIO_THR_MASK = 8'hDF;
  // reset values
  localparam logic [PPIO_W-1:0] PPIO_RST_WORD = 16'h0000;
  localparam logic [7:0] PPIO_RST_THR = 8'h00;

  typedef struct packed {
    logic [PPIO_W-1:0] rdData;
  } ppio_rsp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [PPIO_W-1:0] wrData;
    logic wrStb;
    logic rdStb;
  } ppio_req_t;

  typedef struct packed {
    logic [PPIO_NBI-1:0][PPIO_W-1:0] own;
    logic [PPIO_NBI-1:0][PPIO_W-1:0] dout;
    logic [PPIO_NBI-1:0][PPIO_W-1:0] oe;
  } ppio_periph_t;
endpackage

//--- hw/ppio_sync.sv
// ppio_sync: two-flop synchroniser for one 16-bit group of pad inputs
// assumes pads are asynchronous to clk_sys; second stage is the input latch
`timescale 1ns/10ps
module ppio_sync
  import ppio_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // pad side
  input wire logic [PPIO_W-1:0] padIn,
  // latched level
  output logic [PPIO_W-1:0] latched
);
  logic [PPIO_W-1:0] stage1;
  logic [PPIO_W-1:0] next_stage1;
  logic [PPIO_W-1:0] next_latched;

  always_comb
  begin
    next_stage1 = ce ? padIn : stage1;
    next_latched = ce ? stage1 : latched;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= PPIO_RST_WORD;
      latched <= PPIO_RST_WORD;
    end
    else
    begin
      stage1 <= next_stage1;
      latched <= next_latched;
    end
  end
endmodule // ppio_sync

//--- hw/ppio_ports.sv
// ppio_ports: general purpose parallel port logic with register port
// assumes single-cycle strobes from logic on clk_sys; pads are asynchronous
`timescale 1ns/10ps
module ppio_ports
  import ppio_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire ppio_pkg::ppio_req_t req,
  output ppio_pkg::ppio_rsp_t rsp,
  // extension port enables from system configuration
  input wire logic extension_bus_periph_enable,
  input wire logic extension_peripheral_select,
  // peripheral and bus controller takeover
  input wire ppio_pkg::ppio_periph_t periph,
  // pads
  input wire logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] padIn,
  output logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOut,
  output logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOe,
  // pad electrical settings
  output logic [ppio_pkg::PPIO_NDRV-1:0][ppio_pkg::PPIO_W-1:0] output_driver_control,
  output logic [ppio_pkg::PPIO_W-1:0] bus_strobe_driver_control,
  output logic [7:0] input_threshold_select,
  // latched pin levels for on-chip peripherals
  output logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] pinLevel
);
  import ppio_pkg::*;

  logic [PPIO_NALL-1:0][PPIO_W-1:0] inLatch;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] outLatch;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] pin_direction_bit;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] open_drain_select;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] next_outLatch;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] next_dir;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] next_od;
  logic [PPIO_NDRV-1:0][PPIO_W-1:0] next_drv;
  logic [PPIO_W-1:0] next_strb;
  logic [7:0] next_thr;
  logic [PPIO_W-1:0] next_rdData;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] next_padOut;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] next_padOe;
  logic extEnable;
  logic [PPIO_NALL-1:0][PPIO_W-1:0] syncOut;
  logic [PPIO_NALL-1:0][PPIO_W-1:0] next_pinLevel;

  // software-visible port value: latch for outputs, pin level for inputs
  function automatic logic [PPIO_W-1:0] portView(
    input logic [PPIO_W-1:0] dir,
    input logic [PPIO_W-1:0] latch,
    input logic [PPIO_W-1:0] level
  );
    portView = (dir & latch) | (~dir & level);
  endfunction

  // index of a register within a bank, or an out-of-range marker
  function automatic int bankIndex(
    input logic [7:0] addr,
    input logic [7:0] base,
    input int count
  );
    logic [7:0] off;
    off = addr - base;
    if (addr >= base && int'(off) < count)
      bankIndex = int'(off);
    else
      bankIndex = -1;
  endfunction

  // set or clear the given bits of the read view, unimplemented bits kept zero
  function automatic logic [PPIO_W-1:0] rmwValue(
    input logic [PPIO_W-1:0] rdView,
    input logic [PPIO_W-1:0] bits,
    input logic doSet,
    input logic [PPIO_W-1:0] mask
  );
    if (doSet)
      rmwValue = (rdView | bits) & mask;
    else
      rmwValue = (rdView & ~bits) & mask;
  endfunction

  // extension port a takes software writes only while both enables are set
  function automatic logic portWritable(
    input int idx,
    input logic enable
  );
    portWritable = (idx != PPIO_XA) || enable;
  endfunction

  // both outside enables are needed before the extension ports work
  assign extEnable = extension_bus_periph_enable & extension_peripheral_select;

  genvar g;
  generate
    for (g = 0; g < PPIO_NALL; g++)
    begin : gSync
      ppio_sync uSync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .padIn(padIn[g]),
        .latched(syncOut[g])
      );
      // unimplemented bits read as zero, masked after the second flop
      assign inLatch[g] = syncOut[g] & PPIO_PORT_MASK[g];
    end
  endgenerate

  // register writes and reads
  always_comb
  begin
    int k;
    logic [PPIO_W-1:0] view;
    k = 0;
    view = PPIO_RST_WORD;
    next_outLatch = outLatch;
    next_dir = pin_direction_bit;
    next_od = open_drain_select;
    next_drv = output_driver_control;
    next_strb = bus_strobe_driver_control;
    next_thr = input_threshold_select;
    next_rdData = PPIO_RST_WORD;
    if (ce && req.wrStb)
    begin
      if (bankIndex(req.addr, PPIO_DATA_BASE, PPIO_NBI) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DATA_BASE, PPIO_NBI);
        // write goes to the latch whatever the direction
        if (portWritable(k, extEnable))
          next_outLatch[k] = req.wrData & PPIO_PORT_MASK[k];
      end
      else if (bankIndex(req.addr, PPIO_DIR_BASE, PPIO_NBI) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DIR_BASE, PPIO_NBI);
        if (portWritable(k, extEnable))
          next_dir[k] = req.wrData & PPIO_PORT_MASK[k];
      end
      else if (bankIndex(req.addr, PPIO_SET_BASE, PPIO_NDRV) >= 0)
      begin
        // bit set: hardware read-modify-write, not on extension ports
        k = bankIndex(req.addr, PPIO_SET_BASE, PPIO_NDRV);
        view = portView(pin_direction_bit[k], outLatch[k], inLatch[k]);
        next_outLatch[k] = rmwValue(view, req.wrData, 1'b1, PPIO_PORT_MASK[k]);
      end
      else if (bankIndex(req.addr, PPIO_CLR_BASE, PPIO_NDRV) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_CLR_BASE, PPIO_NDRV);
        view = portView(pin_direction_bit[k], outLatch[k], inLatch[k]);
        next_outLatch[k] = rmwValue(view, req.wrData, 1'b0, PPIO_PORT_MASK[k]);
      end
      else if (bankIndex(req.addr, PPIO_OD_BASE, PPIO_NBI) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_OD_BASE, PPIO_NBI);
        if (PPIO_OD_PORTS[k] && portWritable(k, extEnable))
          next_od[k] = req.wrData & PPIO_PORT_MASK[k];
      end
      else if (bankIndex(req.addr, PPIO_DRV_BASE, PPIO_NDRV) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DRV_BASE, PPIO_NDRV);
        next_drv[k] = req.wrData;
      end
      else if (req.addr == PPIO_STRB_DRV)
      begin
        next_strb = req.wrData;
      end
      else if (req.addr == PPIO_THR_SEL)
      begin
        next_thr = req.wrData[7:0] & PPIO_THR_MASK;
      end
    end
    if (ce && req.rdStb)
    begin
      if (bankIndex(req.addr, PPIO_DATA_BASE, PPIO_NALL) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DATA_BASE, PPIO_NALL);
        if (k >= PPIO_NBI)
          next_rdData = inLatch[k];
        else
          next_rdData = portView(pin_direction_bit[k], outLatch[k], inLatch[k]);
        if ((k == PPIO_XA || k == PPIO_XB) && !extEnable)
          next_rdData = PPIO_RST_WORD;
      end
      else if (bankIndex(req.addr, PPIO_DIR_BASE, PPIO_NBI) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DIR_BASE, PPIO_NBI);
        next_rdData = pin_direction_bit[k];
      end
      else if (bankIndex(req.addr, PPIO_OD_BASE, PPIO_NBI) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_OD_BASE, PPIO_NBI);
        next_rdData = open_drain_select[k];
      end
      else if (bankIndex(req.addr, PPIO_DRV_BASE, PPIO_NDRV) >= 0)
      begin
        k = bankIndex(req.addr, PPIO_DRV_BASE, PPIO_NDRV);
        next_rdData = output_driver_control[k];
      end
      else if (req.addr == PPIO_STRB_DRV)
      begin
        next_rdData = bus_strobe_driver_control;
      end
      else if (req.addr == PPIO_THR_SEL)
      begin
        next_rdData = {8'h00, input_threshold_select};
      end
    end
    else if (!ce)
    begin
      // frozen clock enable keeps the last read data
      next_rdData = rsp.rdData;
    end
  end

  // pad drive: peripheral ownership first, then software gpio
  always_comb
  begin
    logic [PPIO_W-1:0] swOe;
    logic [PPIO_W-1:0] swOut;
    swOe = PPIO_RST_WORD;
    swOut = PPIO_RST_WORD;
    for (int p = 0; p < PPIO_NBI; p++)
    begin
      // open drain: only drive low, a latch one floats
      swOe = pin_direction_bit[p] & ~(open_drain_select[p] & outLatch[p]);
      swOut = outLatch[p] & ~open_drain_select[p];
      next_padOe[p] = ((periph.own[p] & periph.oe[p]) | (~periph.own[p] & swOe))
                      & PPIO_PORT_MASK[p];
      next_padOut[p] = ((periph.own[p] & periph.dout[p]) | (~periph.own[p] & swOut))
                       & PPIO_PORT_MASK[p];
      // a disabled extension port keeps its pins released
      if (p == PPIO_XA && !extEnable)
      begin
        next_padOe[p] = PPIO_RST_WORD;
        next_padOut[p] = PPIO_RST_WORD;
      end
      if (!ce)
      begin
        next_padOe[p] = padOe[p];
        next_padOut[p] = padOut[p];
      end
    end
  end

  // copy of the input latches for on-chip peripherals, frozen with the enable
  always_comb
  begin
    next_pinLevel = ce ? inLatch : pinLevel;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      outLatch <= '0;
      pin_direction_bit <= '0;
      open_drain_select <= '0;
      output_driver_control <= '0;
      bus_strobe_driver_control <= PPIO_RST_WORD;
      input_threshold_select <= PPIO_RST_THR;
      rsp <= '0;
      padOut <= '0;
      padOe <= '0;
      pinLevel <= '0;
    end
    else
    begin
      // each next value already holds its register while ce is low
      outLatch <= next_outLatch;
      pin_direction_bit <= next_dir;
      open_drain_select <= next_od;
      output_driver_control <= next_drv;
      bus_strobe_driver_control <= next_strb;
      input_threshold_select <= next_thr;
      rsp.rdData <= next_rdData;
      padOut <= next_padOut;
      padOe <= next_padOe;
      pinLevel <= next_pinLevel;
    end
  end
endmodule // ppio_ports

//--- verif/ppio_pad_model.sv
// ppio_pad_model: board side of the pins, drives them or pulls them up
// assumes padOe high means the block drives the pin
`timescale 1ns/10ps
module ppio_pad_model (
  // block drive
  input wire logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOut,
  input wire logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOe,
  // board drive
  input wire logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] boardEn,
  input wire logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] boardVal,
  // resolved level
  output logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] padIn
);
  import ppio_pkg::*;
  // lines nobody drives sit at the pull-up level
  always_comb
  begin
    for (int i = 0; i < PPIO_NALL; i++)
    begin
      padIn[i] = (boardVal[i] & boardEn[i]) | ~boardEn[i];
      if (i < PPIO_NBI)
        padIn[i] = (padOut[i] & padOe[i]) | (padIn[i] & ~padOe[i]);
    end
  end
endmodule // ppio_pad_model

//--- verif/ppio_ports_checker.sv
// ppio_ports_checker: port-level assertions for the parallel port block
// assumes it is bound into ppio_ports and sees only its ports
`timescale 1ns/10ps
module ppio_ports_checker (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  // register port and enables
  input wire ppio_pkg::ppio_req_t req,
  input wire ppio_pkg::ppio_rsp_t rsp,
  input wire logic extension_bus_periph_enable,
  input wire logic extension_peripheral_select,
  // takeover and pads
  input wire ppio_pkg::ppio_periph_t periph,
  input wire logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] padIn,
  input wire logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOut,
  input wire logic [ppio_pkg::PPIO_NBI-1:0][ppio_pkg::PPIO_W-1:0] padOe,
  input wire logic [7:0] input_threshold_select,
  input wire logic [ppio_pkg::PPIO_NALL-1:0][ppio_pkg::PPIO_W-1:0] pinLevel
);
  import ppio_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_rst_inputs: assert property ($rose(rst_b) |-> padOe == '0)
    else $error("pads driven right after reset");
  a_pin_latch: assert property (ce [*3] |=> pinLevel[11] == $past(padIn[11], 3))
    else $error("pin level not latched in time");
  a_rd_input: assert property (ce && req.rdStb && req.addr == 8'h0B |=>
    rsp.rdData == pinLevel[11]) else $error("input read is not the latched pin");
  a_ext_off: assert property (ce && req.rdStb && req.addr == 8'h0C &&
    !(extension_bus_periph_enable && extension_peripheral_select) |=> rsp.rdData == 16'h0000)
    else $error("disabled extension port readable");
  a_oe_input: assert property (ce && req.wrStb && req.addr == 8'h14 &&
    req.wrData == 16'h0000 ##1 ce && !req.wrStb && periph.own[4] == 16'h0000 |=>
    padOe[4] == 16'h0000) else $error("input pin still driven");
  a_own_pass: assert property (ce && periph.own[4] == 16'hFFFF |=>
    padOut[4] == $past(periph.dout[4]) && padOe[4] == $past(periph.oe[4]))
    else $error("peripheral takeover not passed to pins");
  a_unused_zero: assert property (padOe[0][15:8] == 8'h00 && padOut[5][14] == 1'b0)
    else $error("unimplemented pin bit active");
  a_thr_gap: assert property (input_threshold_select[5] == 1'b0)
    else $error("unused threshold bit set");
endmodule // ppio_ports_checker

bind ppio_ports ppio_ports_checker u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .req(req), .rsp(rsp),
  .extension_bus_periph_enable(extension_bus_periph_enable),
  .extension_peripheral_select(extension_peripheral_select), .periph(periph),
  .padIn(padIn), .padOut(padOut), .padOe(padOe),
  .input_threshold_select(input_threshold_select), .pinLevel(pinLevel)
);

//--- verif/test_parallel_io_ports.sv
// test_parallel_io_ports: self-checking bench for the parallel port block
// assumes the pad model stands on the pins and the checker is bound in
`timescale 1ns/10ps
module test_parallel_io_ports;
  import ppio_pkg::*;
  typedef struct packed { logic [7:0] a; logic [15:0] w; logic [15:0] e; } ppio_row_t;
  localparam ppio_row_t ROWS [11] = '{
    '{8'h50, 16'hFFFF, 16'hFFFF}, '{8'h59, 16'hA5A5, 16'hA5A5}, '{8'h5A, 16'h1234, 16'h1234},
    '{8'h5B, 16'h00FF, 16'h00DF}, '{8'h40, 16'hFFFF, 16'h0000}, '{8'h44, 16'hFFFF, 16'hFFFF},
    '{8'h15, 16'hFFFF, 16'hBFFF}, '{8'h10, 16'hFFFF, 16'h00FF}, '{8'h1A, 16'hFFFF, 16'h0000},
    '{8'h7F, 16'h1234, 16'h0000}, '{8'h0B, 16'h0000, 16'h3C3C}};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic xEn = 1'b0;
  ppio_req_t req = '0;
  ppio_rsp_t rsp;
  ppio_periph_t periph = '0;
  logic [PPIO_NALL-1:0][PPIO_W-1:0] padIn, boardEn, boardVal;
  logic [PPIO_NBI-1:0][PPIO_W-1:0] padOut, padOe;
  logic [PPIO_NDRV-1:0][PPIO_W-1:0] drvCtl;
  logic [PPIO_W-1:0] strbCtl;
  logic [7:0] thrSel;
  logic [PPIO_NALL-1:0][PPIO_W-1:0] pinLevel;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  ppio_ports u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .req(req), .rsp(rsp),
    .extension_bus_periph_enable(xEn), .extension_peripheral_select(xEn),
    .periph(periph), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .output_driver_control(drvCtl), .bus_strobe_driver_control(strbCtl),
    .input_threshold_select(thrSel), .pinLevel(pinLevel)
  );
  ppio_pad_model u_pad (
    .padOut(padOut), .padOe(padOe), .boardEn(boardEn), .boardVal(boardVal), .padIn(padIn)
  );
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge clk_sys);
    req <= '{a, w, 1'b1, 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 chk(rsp.rdData, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    boardEn = '1;
    boardVal = '0;
    boardVal[4] = 16'h5A5A;
    boardVal[5] = 16'hFFFF;
    boardVal[11] = 16'h3C3C;
    boardVal[12] = 16'hC3C3;
    do_reset();
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].w);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    chk(drvCtl[0], 16'hFFFF);
    chk(drvCtl[9], 16'hA5A5);
    chk(strbCtl, 16'h1234);
    chk({8'h00, thrSel}, 16'h00DF);
    chk(pinLevel[11], 16'h3C3C);
    chk(pinLevel[4], 16'h5A5A);
    chk(pinLevel[5], 16'h0000);
    // second reset, then a write while the clock enable is low
    @(posedge clk_sys);
    do_reset();
    ce <= 1'b0;
    wr(8'h5A, 16'hFFFF);
    ce <= 1'b1;
    rdc(8'h5A, 16'h0000);
    rdc(8'h14, 16'h0000);
    chk(padOe[4], 16'h0000);
    wr(8'h04, 16'h00FF);
    rdc(8'h04, 16'h5A5A);
    wr(8'h24, 16'h0100);
    wr(8'h14, 16'hFFFF);
    rdc(8'h04, 16'h5B5A);
    chk(padOut[4], 16'h5B5A);
    chk(padOe[4], 16'hFFFF);
    wr(8'h34, 16'h000F);
    rdc(8'h04, 16'h5B50);
    chk(padOut[4], 16'h5B50);
    wr(8'h44, 16'hFFFF);
    settle();
    chk(padOe[4], 16'hA4AF);
    chk(padOut[4], 16'h0000);
    wr(8'h14, 16'h0000);
    settle();
    chk(padOe[4], 16'h0000);
    @(posedge clk_sys);
    periph.own[4] <= 16'hFFFF;
    periph.dout[4] <= 16'h0F0F;
    periph.oe[4] <= 16'hFFFF;
    settle();
    chk(padOut[4], 16'h0F0F);
    chk(padOe[4], 16'hFFFF);
    @(posedge clk_sys);
    xEn <= 1'b1;
    wr(8'h1A, 16'hFFFF);
    wr(8'h0A, 16'h1234);
    wr(8'h2A, 16'h0001);
    rdc(8'h0A, 16'h1234);
    chk(padOut[10], 16'h1234);
    rdc(8'h0C, 16'hC3C3);
    @(posedge clk_sys);
    xEn <= 1'b0;
    rdc(8'h0C, 16'h0000);
    complete_run();
  end
endmodule // test_parallel_io_ports
